// File: src/mgt_consts.svh
// timing counts and reset values of the measurement gate time base
`ifndef MGT_CONSTS_SVH
`define MGT_CONSTS_SVH
`define MGT_DECADES 7
`define MGT_DIGIT_PRESET 4'h9
`define MGT_FIRST_PRESET 4'h0
`define MGT_DIGIT_LAST 4'h9
`define MGT_END_PULSE_NS 16
`define MGT_CLK_NS 8
`define MGT_END_PULSE_CYC ((`MGT_END_PULSE_NS + `MGT_CLK_NS - 1) / `MGT_CLK_NS)
`define MGT_HOLD_DEFAULT 32'h0000_1000
`define MGT_SEL_1MS 3'h0
`define MGT_ADDR_CTRL 12'h000
`define MGT_ADDR_STAT 12'h004
`define MGT_ADDR_COUNT 12'h008
`define MGT_CTRL_MODE_BIT 4
`define MGT_CTRL_HOLD_BIT 5
`define MGT_CTRL_INF_BIT 6
`endif

// File: src/mgt_pkg.sv
// shared types of the measurement gate time base
package mgt_pkg;
    // front panel controls as one packed group
    typedef struct packed {
        logic reset_button;
        logic reset_jack;
        logic manual_on;
        logic manual_off;
        logic external_window_in;
    } mgt_panel_t;
    // complementary window outputs and window lamp
    typedef struct packed {
        logic window_true;
        logic window_comp;
        logic window_lamp;
    } mgt_window_t;
    typedef enum logic [2:0] {
        MGT_HOLD_IDLE = 3'b001,
        MGT_HOLD_RUN = 3'b010,
        MGT_HOLD_FIRE = 3'b100
    } mgt_hold_t;
endpackage

// File: src/mgt_timebase.sv
// measurement window time base, gate control, readout enable and hold timer
//
// Summary of operation
// R1: seven cascaded divide-by-ten reference decades
// R2: decades step on falling edge of predecessor
// R3: chain clear presets divider to 9999990
// R4: reset high while button or jack high
// R5: reset high forces window closed
// R6: window async set/clear beat J-K clock
// R7: manual on opens, manual off closes
// R8: external rising edge opens window when off
// R9: external falling edge closes window when off
// R10: interval mode ignores manual and external inputs
// R11: chain clear rising edge sets arming latch
// R12: window end pulse clears arming latch
// R13: toggle flop J=arming, K=own output, cleared
// R14: selected decade clocks toggle; outputs feed window
// R15: J-K falling-edge hold/clear/set/toggle table
// R16: window clocked by gated reference falling edge
// R17: complementary window outputs and window lamp
// R18: short low end pulse when window closes
// R19: readout enable held low in manual, no-hold
// R20: otherwise readout enable on end or reset
// R21: hold timer inhibited while open or infinite
// R22: finite hold fires one chain-clear pulse
// R23: reference gated to window only in interval mode
// R24: selector picks one of last five decades
// R25: chain clear on hold pulse or reset
// R26: synchronised inputs, single-cycle set strobes
//
// Implementation choices: the APB slave port and the register offsets.
`include "mgt_consts.svh"
module mgt_timebase
    import mgt_pkg::*;
#(
    parameter logic [31:0] HOLD_CYCLES = `MGT_HOLD_DEFAULT
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reference_in,
    input wire mgt_panel_t panel,
    output mgt_window_t window_out,
    output logic window_end_n,
    output logic readout_enable_n,
    output logic chain_clear,
    output logic reset_level
);

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [11:0] ADDR_CTRL = `MGT_ADDR_CTRL;
    localparam logic [11:0] ADDR_STAT = `MGT_ADDR_STAT;
    localparam logic [11:0] ADDR_COUNT = `MGT_ADDR_COUNT;

    logic [2:0] interval_sel_q;  // 0..4 = 1e3..1e7
    logic interval_mode_q;       // high selects timed window
    logic hold_switch_q;         // manual gate storage on
    logic hold_infinite_q;
    logic [3:0] digit_q [0:`MGT_DECADES-1];
    logic window_q;
    logic arming_latch_q;
    logic interval_toggle_flop_q;

    wire logic apb_wr = psel && penable && pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && (paddr != ADDR_CTRL) && (paddr != ADDR_STAT) && (paddr != ADDR_COUNT);

    // control register, written in the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            interval_sel_q <= `MGT_SEL_1MS;
            interval_mode_q <= 1'b0;
            hold_switch_q <= 1'b0;
            hold_infinite_q <= 1'b0;
        end
        else if (apb_wr && paddr == ADDR_CTRL)
        begin
            // selections above 4 clamp to the slowest tap
            interval_sel_q <= (pwdata[2:0] > 3'h4) ? 3'h4 : pwdata[2:0]; // R24
            interval_mode_q <= pwdata[`MGT_CTRL_MODE_BIT];
            hold_switch_q <= pwdata[`MGT_CTRL_HOLD_BIT];
            hold_infinite_q <= pwdata[`MGT_CTRL_INF_BIT];
        end
    end

    // read data is caught in the setup phase so it stands from a flop through the access phase;
    // the price is that status bits are one cycle old when the transfer completes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable)
        begin
            // unmapped reads return zero with an error
            case (paddr)
                ADDR_CTRL: prdata <= {25'h0, hold_infinite_q, hold_switch_q, interval_mode_q, 1'b0, interval_sel_q};
                ADDR_STAT: prdata <= {28'h0, chain_clear, interval_toggle_flop_q, arming_latch_q, window_q};
                ADDR_COUNT: prdata <= {4'h0, digit_q[6], digit_q[5], digit_q[4], digit_q[3], digit_q[2],
                    digit_q[1], digit_q[0]};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    localparam int NSYNC = 6;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] s1_q, s2_q, s3_q, clean_q;
    assign raw_in = {reference_in, panel.reset_button, panel.reset_jack, panel.manual_on, panel.manual_off,
        panel.external_window_in};

    // three flops; a change counts once the last two agree
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            clean_q <= '0;
        end
        else
        begin
            s1_q <= raw_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            clean_q <= (s2_q & s3_q) | (clean_q & (s2_q | s3_q)); // R26
        end
    end

    wire logic ref_s = clean_q[5];
    wire logic man_on_s = clean_q[2];
    wire logic man_off_s = clean_q[1];
    wire logic ext_s = clean_q[0];
    logic ref_prev_q, ext_prev_q, clear_prev_q, window_prev_q;

    // ****************************************************************
    // reset input and chain clear
    // ****************************************************************
    logic hold_pulse;
    assign reset_level = clean_q[4] | clean_q[3]; // R4
    assign chain_clear = hold_pulse | reset_level; // R25

    // ****************************************************************
    // reference decade divider
    // ****************************************************************
    wire logic ref_fall = ref_prev_q && !ref_s; // R2
    logic [`MGT_DECADES:0] carry;
    assign carry[0] = ref_fall;

    genvar gi;
    generate
        for (gi = 0; gi < `MGT_DECADES; gi++)
        begin : g_decade
            // carry out when digit wraps 9 to 0: output bit falls then
            assign carry[gi+1] = carry[gi] && (digit_q[gi] == `MGT_DIGIT_LAST); // R1
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    digit_q[gi] <= (gi == 0) ? `MGT_FIRST_PRESET : `MGT_DIGIT_PRESET;
                else if (chain_clear)
                    digit_q[gi] <= (gi == 0) ? `MGT_FIRST_PRESET : `MGT_DIGIT_PRESET; // R3
                else if (carry[gi])
                    digit_q[gi] <= (digit_q[gi] == `MGT_DIGIT_LAST) ? 4'h0 : digit_q[gi] + 4'h1; // R2
            end
        end
    endgenerate

    // interval toggle clocked by falling edge of chosen decade output
    wire logic tap_fall = carry[3'd3 + interval_sel_q]; // R14 R24

    // J-K next state, shared by both flops
    function automatic logic jk_next(input logic q, input logic j, input logic k);
        case ({j, k})
            2'b00: jk_next = q;
            2'b01: jk_next = 1'b0;
            2'b10: jk_next = 1'b1;
            default: jk_next = ~q;
        endcase
    endfunction

    // ****************************************************************
    // edge history
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ref_prev_q <= 1'b0;
            ext_prev_q <= 1'b0;
            clear_prev_q <= 1'b0;
            window_prev_q <= 1'b0;
        end
        else
        begin
            ref_prev_q <= ref_s;
            ext_prev_q <= ext_s;
            clear_prev_q <= chain_clear;
            window_prev_q <= window_q;
        end
    end

    // ****************************************************************
    // arming latch and interval toggle
    // ****************************************************************
    logic [1:0] end_cnt_q;
    wire logic clear_rise = chain_clear && !clear_prev_q; // R11

    // set strobe wins over the end pulse clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            arming_latch_q <= 1'b0;
        else if (clear_rise)
            arming_latch_q <= 1'b1; // R11
        else if (!window_end_n)
            arming_latch_q <= 1'b0; // R12
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            interval_toggle_flop_q <= 1'b0;
        else if (chain_clear)
            interval_toggle_flop_q <= 1'b0; // R13
        else if (tap_fall)
            interval_toggle_flop_q <= jk_next(interval_toggle_flop_q, arming_latch_q,
                interval_toggle_flop_q); // R13 R15
    end

    // ****************************************************************
    // window flip-flop
    // ****************************************************************
    wire logic manual_en = !interval_mode_q; // R10
    wire logic ext_rise = ext_s && !ext_prev_q;
    wire logic ext_fall = !ext_s && ext_prev_q;
    // direct set: manual on, or external rising strobe under manual off
    wire logic win_set = manual_en && (man_on_s || (man_off_s && ext_rise)); // R7 R8
    // direct clear: reset, or manual off with external low
    wire logic win_clr = reset_level || (manual_en && man_off_s && (!ext_s || ext_fall)); // R5 R7 R9
    wire logic win_clk = interval_mode_q && ref_fall; // R23 R16

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            window_q <= 1'b0;
        else if (win_clr)
            window_q <= 1'b0; // R5 R6
        else if (win_set)
            window_q <= 1'b1; // R6
        else if (win_clk)
            window_q <= jk_next(window_q, interval_toggle_flop_q, !interval_toggle_flop_q); // R14 R15 R16
    end

    // outputs come straight from the window flop
    assign window_out.window_true = window_q; // R17
    assign window_out.window_comp = !window_q; // R17
    assign window_out.window_lamp = window_q; // R17

    // ****************************************************************
    // window end pulse and readout enable
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            end_cnt_q <= 2'h0;
        else if (window_prev_q && !window_q)
            end_cnt_q <= 2'(`MGT_END_PULSE_CYC); // R18
        else if (end_cnt_q != 2'h0)
            end_cnt_q <= end_cnt_q - 2'h1;
    end
    assign window_end_n = (end_cnt_q == 2'h0); // R18

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            readout_enable_n <= 1'b1;
        else if (!interval_mode_q && !hold_switch_q)
            readout_enable_n <= 1'b0; // R19
        else
            readout_enable_n <= !(!window_end_n || reset_level); // R20
    end

    // ****************************************************************
    // display hold timer
    // ****************************************************************
    mgt_hold_t hold_state_q;
    logic [31:0] hold_cnt_q;
    wire logic hold_inhibit = window_q || hold_infinite_q; // R21

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hold_state_q <= MGT_HOLD_IDLE;
            hold_cnt_q <= 32'h0;
        end
        else
        begin
            case (hold_state_q)
                MGT_HOLD_IDLE:
                begin
                    hold_cnt_q <= 32'h0;
                    if (!hold_inhibit && !arming_latch_q && !chain_clear)
                        hold_state_q <= MGT_HOLD_RUN; // R22
                end
                MGT_HOLD_RUN:
                begin
                    if (hold_inhibit || arming_latch_q)
                        hold_state_q <= MGT_HOLD_IDLE; // R21
                    else if (hold_cnt_q >= HOLD_CYCLES - 32'h1)
                        hold_state_q <= MGT_HOLD_FIRE;
                    else
                        hold_cnt_q <= hold_cnt_q + 32'h1;
                end
                MGT_HOLD_FIRE: hold_state_q <= MGT_HOLD_IDLE;
                default: hold_state_q <= MGT_HOLD_IDLE;
            endcase
        end
    end
    assign hold_pulse = (hold_state_q == MGT_HOLD_FIRE); // R22

    // ****************************************************************
    // assertions
    // ****************************************************************
    a_reset_level: assert property (@(posedge pclk) disable iff (!presetn) // R4
        (s2_q[4] && s3_q[4]) |=> reset_level) else $error("reset level not raised");
    a_reset_release: assert property (@(posedge pclk) disable iff (!presetn) // R4
        (!s2_q[4] && !s3_q[4] && !s2_q[3] && !s3_q[3]) |=> !reset_level) else $error("reset level stuck");
    a_reset_closes: assert property (@(posedge pclk) disable iff (!presetn) // R5
        reset_level |=> !window_q) else $error("window open during reset");
    a_preset_chain: assert property (@(posedge pclk) disable iff (!presetn) // R3
        chain_clear |=> (digit_q[0] == 4'h0 && digit_q[6] == 4'h9)) else $error("chain preset wrong");
    a_arm_set: assert property (@(posedge pclk) disable iff (!presetn) // R11
        $rose(chain_clear) |=> arming_latch_q) else $error("arming latch not set");
    a_end_pulse: assert property (@(posedge pclk) disable iff (!presetn) // R18
        $fell(window_q) |=> !window_end_n) else $error("no end pulse");
    a_end_clears_arm: assert property (@(posedge pclk) disable iff (!presetn) // R12
        (!window_end_n && !clear_rise) |=> !arming_latch_q) else $error("arming latch not cleared");
    a_toggle_clear: assert property (@(posedge pclk) disable iff (!presetn) // R13
        chain_clear |=> !interval_toggle_flop_q) else $error("toggle not cleared");
    a_interval_ignore: assert property (@(posedge pclk) disable iff (!presetn) // R10
        (interval_mode_q && !reset_level && !win_clk) |=> window_q == $past(window_q))
        else $error("manual input touched window");
    a_ext_opens: assert property (@(posedge pclk) disable iff (!presetn) // R8
        (manual_en && man_off_s && ext_rise && !reset_level) |=> window_q) else $error("external rise ignored");
    a_digit_step: assert property (@(posedge pclk) disable iff (!presetn) // R2
        (carry[0] && !chain_clear && digit_q[0] != 4'h9) |=> digit_q[0] == $past(digit_q[0]) + 4'h1)
        else $error("first decade did not step");
    a_readout_manual: assert property (@(posedge pclk) disable iff (!presetn) // R19
        (!interval_mode_q && !hold_switch_q) |=> !readout_enable_n) else $error("readout not held");
    a_hold_inhibit: assert property (@(posedge pclk) disable iff (!presetn) // R21
        window_q |-> !hold_pulse ##1 !hold_pulse) else $error("hold fired while open");
    c_window_open: cover property (@(posedge pclk) disable iff (!presetn) $rose(window_q));
    c_window_close: cover property (@(posedge pclk) disable iff (!presetn) $fell(window_q) && interval_mode_q);
    c_hold_fire: cover property (@(posedge pclk) disable iff (!presetn) hold_pulse);
    c_ext_open: cover property (@(posedge pclk) disable iff (!presetn) ext_rise && win_set);
    c_interval_arm: cover property (@(posedge pclk) disable iff (!presetn) $rose(interval_toggle_flop_q));

endmodule

// File: dv/mgt_far_side.sv
// far-side model: front panel, reference source and window length probe
module mgt_far_side
    import mgt_pkg::*;
#(
    parameter int REF_HALF = 6
)
(
    input wire logic pclk,
    input wire logic ref_run,
    input wire mgt_window_t window_out,
    output logic reference_in,
    output mgt_panel_t panel,
    output logic [31:0] last_width
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // reference source and count path probe
    // ************************************************************
    logic [7:0] phase_q;
    logic [31:0] open_q;

    initial
    begin
        reference_in = 1'b0;
        panel = '0;
        phase_q = 8'h00;
        open_q = 32'h0000_0000;
        last_width = 32'h0000_0000;
    end

    // panel levels change just after an edge, like a real bounce-free switch
    task automatic press(input logic [4:0] v);
        @(posedge pclk);
        panel <= v;
    endtask

    // reference stands low between runs so no stray decade steps occur
    always @(posedge pclk)
    begin
        if (!ref_run)
        begin
            phase_q <= 8'h00;
            reference_in <= 1'b0;
        end
        else if (phase_q == 8'(REF_HALF - 1))
        begin
            phase_q <= 8'h00;
            reference_in <= !reference_in;
        end
        else
            phase_q <= phase_q + 8'h01;
    end

    // length of the last window in clock cycles, as the count path sees it
    always @(posedge pclk)
    begin
        if (window_out.window_true === 1'b1)
            open_q <= open_q + 32'h0000_0001;
        else
        begin
            if (open_q != 32'h0000_0000)
                last_width <= open_q;
            open_q <= 32'h0000_0000;
        end
    end
endmodule

// File: dv/measurement_gate_timebase_bench.sv
// self-checking bench of the measurement gate time base
`include "mgt_consts.svh"
module measurement_gate_timebase_bench
    import mgt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // signals and instances
    // ************************************************************
    typedef struct packed {
        logic [31:0] data;
        logic [31:0] mask;
        logic err;
    } mgt_note_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, reference_in, ref_run;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, last_width;
    logic window_end_n, readout_enable_n, chain_clear, reset_level;
    mgt_panel_t panel;
    mgt_window_t window_out;
    mgt_note_t notes[$];
    mgt_note_t note;
    int fails, n_tests, cycles, seed;

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // short hold delay keeps the chain-clear wait brief
    mgt_timebase #(.HOLD_CYCLES(32'h0000_0008)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .reference_in(reference_in), .panel(panel),
        .window_out(window_out), .window_end_n(window_end_n), .readout_enable_n(readout_enable_n),
        .chain_clear(chain_clear), .reset_level(reset_level));
    mgt_far_side u_far (.pclk(pclk), .ref_run(ref_run), .window_out(window_out),
        .reference_in(reference_in), .panel(panel), .last_width(last_width));

    // ************************************************************
    // tasks and result checking
    // ************************************************************
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m, input logic err);
        notes.push_back({e, m, err});
        apb(1'b0, a, 32'h0000_0000);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] e, input string what);
        n_tests++;
        if (got !== e)
        begin
            fails++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask

    // oldest note is matched against each completed read
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            note = notes.pop_front();
            n_tests++;
            if (((prdata & note.mask) !== note.data) || (pslverr !== note.err))
            begin
                fails++;
                $display("wrong value at %0t: read %h at %h", $time, prdata, paddr);
            end
        end
    end

    task automatic wait_end();
        int n;
        int lows;
        n = 0;
        lows = 0;
        while (window_end_n !== 1'b0 && n < 40)
        begin
            @(posedge pclk);
            n++;
        end
        while (window_end_n === 1'b0 && lows < 40)
        begin
            @(posedge pclk);
            lows++;
        end
        chk(lows, `MGT_END_PULSE_CYC, "end pulse width");
    endtask

    task automatic clr_pulses(input int e);
        int n;
        int hi;
        hi = 0;
        for (n = 0; n < 40; n++)
        begin
            @(posedge pclk);
            if (chain_clear === 1'b1)
                hi++;
        end
        chk(hi, e, "chain clear pulses");
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // hang guard: whole run needs some 12400 cycles
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            fails++;
            $display("wrong value at %0t: timeout", $time);
            finish_test();
        end
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        int i;
        int n;
        logic [31:0] d;
        logic [2:0] sel;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        ref_run = 1'b0;
        fails = 0;
        n_tests = 0;
        cycles = 0;
        seed = 32'hE84BBD3F;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h008, 32'h0999_9990, 32'h0FFF_FFFF, 1'b0);
        chk(readout_enable_n, 32'h0, "readout in manual no-hold");
        chk(window_out, 32'h2, "window after reset");
        // any word offset past the map must be refused
        d = $random(seed);
        rd({d[11:4], 4'hC}, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
        // random control words; selector clamps to the slowest tap
        for (i = 0; i < 6; i++)
        begin
            d = $random(seed);
            apb(1'b1, 12'h000, d);
            sel = (d[2:0] > 3'h4) ? 3'h4 : d[2:0];
            rd(12'h000, (d & 32'h70) | {29'h0, sel}, 32'h0000_0077, 1'b0);
        end
        apb(1'b1, 12'h000, 32'h0000_0020);
        u_far.press(5'b00100);
        repeat (10) @(posedge pclk);
        chk(window_out, 32'h5, "manual on");
        chk(readout_enable_n, 32'h1, "readout idle while open");
        u_far.press(5'b00010);
        wait_end();
        chk(window_out, 32'h2, "manual off");
        clr_pulses(1);
        rd(12'h004, 32'h2, 32'h3, 1'b0);
        u_far.press(5'b00011);
        repeat (10) @(posedge pclk);
        chk(window_out.window_true, 32'h1, "external rise opens");
        apb(1'b1, 12'h000, 32'h0000_0060);
        u_far.press(5'b00010);
        wait_end();
        chk(window_out.window_true, 32'h0, "external fall closes");
        clr_pulses(0);
        // button or jack, picked at random, together with manual on: clear must win
        d = $random(seed);
        u_far.press({d[0], !d[0], 3'b100});
        repeat (10) @(posedge pclk);
        chk(reset_level, 32'h1, "reset level high");
        chk(chain_clear, 32'h1, "chain clear on reset");
        chk(readout_enable_n, 32'h0, "readout on reset");
        chk(window_out.window_true, 32'h0, "reset closes window");
        u_far.press(5'b00000);
        repeat (10) @(posedge pclk);
        chk(reset_level, 32'h0, "reset level low");
        rd(12'h004, 32'h2, 32'h7, 1'b0);
        rd(12'h008, 32'h0999_9990, 32'h0FFF_FFFF, 1'b0);
        // interval mode, 1e3 tap, infinite hold
        apb(1'b1, 12'h000, 32'h0000_0050);
        u_far.press({2'b00, d[3:2], 1'b1});
        repeat (10) @(posedge pclk);
        chk(window_out.window_true, 32'h0, "panel ignored in interval");
        u_far.press(5'b10000);
        repeat (10) @(posedge pclk);
        u_far.press(5'b00000);
        repeat (10) @(posedge pclk);
        ref_run <= 1'b1;
        n = 0;
        while (window_out.window_true !== 1'b1 && n < 20000)
        begin
            @(posedge pclk);
            n++;
        end
        while (window_out.window_true === 1'b1 && n < 20000)
        begin
            @(posedge pclk);
            n++;
        end
        repeat (4) @(posedge pclk);
        chk(last_width > 32'd11996 && last_width < 32'd12004, 32'h1, "window length");
        rd(12'h004, 32'h0, 32'h3, 1'b0);
        ref_run <= 1'b0;
        finish_test();
    end
endmodule
